//--- rpb_pkg.sv
// Shared constants and types for the reduced-interface transceiver pin block
`default_nettype none
package rpb_pkg;
	// ----------------------------------------------------------------
	// Register map (byte addresses, one 32-bit word each)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] REG_WAKEUP_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
	localparam logic [ADDR_W-1:0] REG_CLEAR = 5'h08;
	localparam logic [ADDR_W-1:0] REG_ENABLE = 5'h0C;
	localparam logic [ADDR_W-1:0] REG_STRAP = 5'h10;
	// ----------------------------------------------------------------
	// Wakeup control fields: indicator function selects
	// ----------------------------------------------------------------
	localparam int SEL_W = 2;
	localparam int LED_A_SEL_LSB = 0;
	localparam int LED_B_SEL_LSB = 2;
	localparam int WAKEUP_CTRL_W = 4;
	localparam logic [WAKEUP_CTRL_W-1:0] WAKEUP_CTRL_RST = 4'h4;
	localparam logic [SEL_W-1:0] LEDSEL_ACTIVITY = 2'h0;
	localparam logic [SEL_W-1:0] LEDSEL_SPEED = 2'h1;
	localparam logic [SEL_W-1:0] LEDSEL_IRQ = 2'h2;
	localparam logic [SEL_W-1:0] LEDSEL_WAKE = 2'h3;
	// ----------------------------------------------------------------
	// Event bits of status, clear and enable registers
	// ----------------------------------------------------------------
	localparam int EV_W = 4;
	localparam int EV_FRAME = 0;
	localparam int EV_RXERR = 1;
	localparam int EV_LINK = 2;
	localparam int EV_WAKE = 3;
	localparam logic [EV_W-1:0] EV_RST = 4'h0;
	// ----------------------------------------------------------------
	// Strap readback layout and defaults (pull-up / pull-down levels)
	// ----------------------------------------------------------------
	localparam int STRAP_W = 5;
	localparam logic [2:0] OPMODE_DEFAULT = 3'h7;
	localparam logic MGMT_ADDR_DEFAULT = 1'b0;
	localparam logic IRQ_SEL_DEFAULT = 1'b1;
	// Covers the four edges the strap synchroniser needs plus the edge that latches its output
	localparam int STRAP_SETTLE = 5;
	// ----------------------------------------------------------------
	// Receive path constants
	// ----------------------------------------------------------------
	localparam logic [7:0] SFD_BYTE = 8'hAB;
	localparam logic [1:0] DIBIT_IDLE = 2'h0;

	typedef struct packed {
		logic carrier;
		logic err;
		logic [1:0] dibit;
	} rpb_rx_line_t;

	typedef struct packed {
		logic [2:0] opmode;
		logic mgmt_addr;
		logic irq_pin_sel;
	} rpb_straps_t;

	localparam rpb_straps_t STRAPS_DEFAULT = '{OPMODE_DEFAULT, MGMT_ADDR_DEFAULT, IRQ_SEL_DEFAULT};
endpackage : rpb_pkg
`default_nettype wire

//--- rpb_sync3.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`default_nettype none
`timescale 1ns/1ps
module rpb_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk, // Core clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic [W-1:0] async_in, // Pin level
	output logic [W-1:0] sync_out // Filtered level
);
	if (W < 1)
	begin : g_bad_width
		$error("rpb_sync3: W must be at least 1");
	end

	logic [W-1:0] s1_reg, s1_next, s2_reg, s2_next, s3_reg, s3_next, out_reg, out_next;

	always_comb
	begin
		s1_next = async_in;
		s2_next = s1_reg;
		s3_next = s2_reg;
		out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
			out_reg <= RST_VAL;
		end
		else
		begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
			out_reg <= out_next;
		end
	end

	assign sync_out = out_reg;
endmodule : rpb_sync3
`default_nettype wire

//--- rpb_strap.sv
// Configuration strap capture window and latch
`default_nettype none
`timescale 1ns/1ps
module rpb_strap
	import rpb_pkg::*;
(
	input wire logic clk, // Core clock
	input wire logic sys_rst, // Power-on reset, synchronous
	input wire logic pin_rst, // Synchronised system reset pin, active high
	input wire rpb_straps_t straps_in, // Synchronised strap levels
	output rpb_straps_t straps_out // Latched straps
);
	rpb_straps_t latch_reg, latch_next;
	logic [2:0] settle_reg, settle_next;
	logic capture;

	// Keep capturing a few cycles past release so the synchronisers have settled
	assign capture = pin_rst || (settle_reg != 3'h0);

	always_comb
	begin
		settle_next = pin_rst ? 3'(STRAP_SETTLE) : (settle_reg != 3'h0 ? settle_reg - 3'h1 : settle_reg);
		latch_next = capture ? straps_in : latch_reg;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			settle_reg <= 3'(STRAP_SETTLE);
			latch_reg <= STRAPS_DEFAULT;
		end
		else
		begin
			settle_reg <= settle_next;
			latch_reg <= latch_next;
		end
	end

	assign straps_out = latch_reg;

	strap_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!capture && !$past(capture) |-> latch_reg == $past(latch_reg))
		else $error("Straps changed outside the capture window");
endmodule : rpb_strap
`default_nettype wire

//--- rpb_top.sv
// Reduced-interface transceiver pin behaviour: receive gating, straps, indicators, interrupts
`default_nettype none
`timescale 1ns/1ps
module rpb_top
	import rpb_pkg::*;
(
	input wire logic clk, // 50 MHz interface reference clock
	input wire logic sys_rst, // Power-on reset, synchronous, active high
	input wire logic system_reset_n, // External system reset pin, active low
	input wire logic refclk_src, // 50 MHz derived from the 25 MHz crystal
	input wire logic [1:0] txd, // Transmit data from the MAC
	input wire logic tx_en, // Transmit enable from the MAC
	output logic [1:0] rxd, // Receive data to the MAC
	output logic crs_dv, // Carrier sense / data valid
	output logic rx_er, // Receive error
	output logic [1:0] tx_line_dibit, // Transmit dibit toward the encoder
	output logic tx_line_en, // Transmit enable toward the encoder
	input wire rpb_rx_line_t rx_line, // Decoded receive stream from the line side
	input wire logic line_speed_10, // Link runs at 10 Mb/s
	input wire logic line_full_duplex, // Link runs full duplex
	input wire logic line_link_up, // Link established
	input wire logic wake_detect, // Wake frame detected, one-cycle pulse
	input wire logic opmode_strap_bit0, // Operating-mode strap bit 0
	input wire logic opmode_strap_bit1, // Operating-mode strap bit 1
	input wire logic opmode_strap_bit2, // Operating-mode strap bit 2
	input wire logic mgmt_addr_strap, // Management address strap
	input wire logic irq_pin_select_strap, // Shared pin function strap
	output logic [2:0] default_opmode, // Latched operating mode
	output logic mgmt_addr, // Latched management address bit
	output logic indicator_out_a, // First indicator
	output logic indicator_out_b, // Second indicator
	output logic irq_out_n, // Interrupt, active low
	output logic wake_event_out_n, // Wake event, active low
	output logic shared_pin_o, // Interrupt/clock pin level
	output logic shared_pin_oe, // Interrupt/clock pin drive enable
	output logic irq, // Level interrupt, active high
	input wire logic [ADDR_W-1:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte enables
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest // Wait request
);
	// ----------------------------------------------------------------
	// Reset pin and straps
	// ----------------------------------------------------------------
	logic rst_pin_n_sync, pin_rst, rst_int;
	rpb_straps_t straps_raw, straps;

	rpb_sync3 #(.W(1), .RST_VAL(1'b1)) u_rst_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in(system_reset_n),
		.sync_out(rst_pin_n_sync)
	);

	rpb_sync3 #(.W(STRAP_W), .RST_VAL(STRAPS_DEFAULT)) u_strap_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in({opmode_strap_bit2, opmode_strap_bit1, opmode_strap_bit0, mgmt_addr_strap, irq_pin_select_strap}),
		.sync_out(straps_raw)
	);

	assign pin_rst = !rst_pin_n_sync;
	assign rst_int = sys_rst || pin_rst;

	rpb_strap u_strap (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_rst(pin_rst),
		.straps_in(straps_raw),
		.straps_out(straps)
	);

	assign default_opmode = straps.opmode;
	assign mgmt_addr = straps.mgmt_addr;

	// ----------------------------------------------------------------
	// Transmit staging and receive gating
	// ----------------------------------------------------------------
	typedef enum {RX_IDLE, RX_HUNT, RX_PASS} rpb_rx_state_t;
	rpb_rx_state_t state_reg, state_next;
	logic [7:0] shift_reg, shift_next;
	logic [1:0] rxd_reg, rxd_next, txd_reg, txd_next;
	logic crs_reg, crs_next, er_reg, er_next, txen_reg, txen_next;
	logic echo_block, live, sfd_hit, frame_start;

	// Half-duplex 10 Mb/s carrier during our own transmit is our echo
	assign echo_block = line_speed_10 && !line_full_duplex && txen_reg;
	assign live = rx_line.carrier && !echo_block;
	assign sfd_hit = (shift_next == SFD_BYTE);

	always_comb
	begin
		txd_next = txd;
		txen_next = tx_en;
		shift_next = live ? {rx_line.dibit, shift_reg[7:2]} : 8'h00;
		state_next = state_reg;
		case (state_reg)
			RX_IDLE:
			begin
				if (live)
					state_next = line_speed_10 ? RX_HUNT : RX_PASS;
			end
			RX_HUNT:
			begin
				if (!live)
					state_next = RX_IDLE;
				else if (sfd_hit)
					state_next = RX_PASS;
			end
			RX_PASS:
			begin
				if (!live)
					state_next = RX_IDLE;
			end
			default: state_next = RX_IDLE;
		endcase
		crs_next = live;
		// Data passes two bits per clock; 10 Mb/s waits for the delimiter
		rxd_next = (live && (!line_speed_10 || state_reg == RX_PASS)) ? rx_line.dibit : DIBIT_IDLE;
		er_next = live && rx_line.err;
	end

	assign frame_start = (state_next == RX_PASS) && (state_reg != RX_PASS);

	always_ff @(posedge clk)
	begin
		if (rst_int)
		begin
			state_reg <= RX_IDLE;
			shift_reg <= 8'h00;
			rxd_reg <= DIBIT_IDLE;
			crs_reg <= 1'b0;
			er_reg <= 1'b0;
			txd_reg <= DIBIT_IDLE;
			txen_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			rxd_reg <= rxd_next;
			crs_reg <= crs_next;
			er_reg <= er_next;
			txd_reg <= txd_next;
			txen_reg <= txen_next;
		end
	end

	assign rxd = rxd_reg;
	assign crs_dv = crs_reg;
	assign rx_er = er_reg;
	assign tx_line_dibit = txd_reg;
	assign tx_line_en = txen_reg;

	// ----------------------------------------------------------------
	// Registers, events and indicators
	// ----------------------------------------------------------------
	logic [WAKEUP_CTRL_W-1:0] wakeup_ctrl_status_reg, wakeup_ctrl_status_next;
	logic [EV_W-1:0] status_reg, status_next, enable_reg, enable_next, ev_set, ev_clr;
	logic [31:0] rdata_reg, rdata_next;
	logic ack_reg, ack_next, link_reg, link_next, irq_reg, irq_next;
	logic led_a_reg, led_a_next, led_b_reg, led_b_next, wake_reg, wake_next;
	logic wr_lo, activity;

	assign wr_lo = avs_write && ack_reg && avs_byteenable[0];
	assign activity = crs_reg || txen_reg;

	function automatic logic led_pick(input logic [SEL_W-1:0] sel, input logic act, input logic spd,
		input logic irq_n, input logic wake_n);
		case (sel)
			LEDSEL_ACTIVITY: led_pick = act;
			LEDSEL_SPEED: led_pick = spd;
			LEDSEL_IRQ: led_pick = irq_n;
			default: led_pick = wake_n;
		endcase
	endfunction : led_pick

	always_comb
	begin
		ack_next = (avs_read || avs_write) && !ack_reg;
		link_next = line_link_up;
		ev_set = '0;
		ev_set[EV_FRAME] = frame_start;
		ev_set[EV_RXERR] = er_next && !er_reg;
		ev_set[EV_LINK] = line_link_up != link_reg;
		ev_set[EV_WAKE] = wake_detect;
		ev_clr = (wr_lo && avs_address == REG_CLEAR) ? avs_writedata[EV_W-1:0] : '0;
		// A new event wins over a clear in the same cycle
		status_next = (status_reg & ~ev_clr) | ev_set;
		enable_next = (wr_lo && avs_address == REG_ENABLE) ? avs_writedata[EV_W-1:0] : enable_reg;
		wakeup_ctrl_status_next = (wr_lo && avs_address == REG_WAKEUP_CTRL) ?
			avs_writedata[WAKEUP_CTRL_W-1:0] : wakeup_ctrl_status_reg;
		irq_next = |(status_next & enable_next);
		wake_next = status_next[EV_WAKE];
		led_a_next = led_pick(wakeup_ctrl_status_next[LED_A_SEL_LSB +: SEL_W], activity, line_speed_10,
			!irq_next, !wake_next);
		led_b_next = led_pick(wakeup_ctrl_status_next[LED_B_SEL_LSB +: SEL_W], activity, line_speed_10,
			!irq_next, !wake_next);
		rdata_next = rdata_reg;
		if (avs_read && !ack_reg)
		begin
			case (avs_address)
				REG_WAKEUP_CTRL: rdata_next = {{(32-WAKEUP_CTRL_W){1'b0}}, wakeup_ctrl_status_reg};
				REG_STATUS: rdata_next = {{(32-EV_W){1'b0}}, status_reg};
				REG_ENABLE: rdata_next = {{(32-EV_W){1'b0}}, enable_reg};
				REG_STRAP: rdata_next = {{(32-STRAP_W){1'b0}}, straps};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst_int)
		begin
			ack_reg <= 1'b0;
			link_reg <= 1'b0;
			status_reg <= EV_RST;
			enable_reg <= EV_RST;
			wakeup_ctrl_status_reg <= WAKEUP_CTRL_RST;
			irq_reg <= 1'b0;
			wake_reg <= 1'b0;
			led_a_reg <= 1'b0;
			led_b_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			ack_reg <= ack_next;
			link_reg <= link_next;
			status_reg <= status_next;
			enable_reg <= enable_next;
			wakeup_ctrl_status_reg <= wakeup_ctrl_status_next;
			irq_reg <= irq_next;
			wake_reg <= wake_next;
			led_a_reg <= led_a_next;
			led_b_reg <= led_b_next;
			rdata_reg <= rdata_next;
		end
	end

	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
	assign avs_readdata = rdata_reg;
	assign irq = irq_reg;
	assign irq_out_n = !irq_reg;
	assign wake_event_out_n = !wake_reg;
	assign indicator_out_a = led_a_reg;
	assign indicator_out_b = led_b_reg;

	// ----------------------------------------------------------------
	// Shared interrupt / reference clock pin
	// ----------------------------------------------------------------
	// Open-drain interrupt pulls low only; the clock is a straight pass of the derived source
	assign shared_pin_o = straps.irq_pin_sel ? 1'b0 : refclk_src;
	assign shared_pin_oe = straps.irq_pin_sel ? irq_reg : 1'b1;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	crs_follow_a: assert property (@(posedge clk) disable iff (rst_int)
		rx_line.carrier && !echo_block |=> crs_dv)
		else $error("Carrier sense missed a busy medium");
	hunt_hold_a: assert property (@(posedge clk) disable iff (rst_int)
		state_reg == RX_HUNT && line_speed_10 |=> rxd == DIBIT_IDLE)
		else $error("Data leaked before the delimiter");
	rx_err_a: assert property (@(posedge clk) disable iff (rst_int)
		live && rx_line.err |=> rx_er && crs_dv)
		else $error("Receive error not flagged");
	no_echo_a: assert property (@(posedge clk) disable iff (rst_int)
		line_speed_10 && !line_full_duplex && txen_reg |=> !crs_dv && rxd == DIBIT_IDLE)
		else $error("Own transmission echoed");
	fast_pass_a: assert property (@(posedge clk) disable iff (rst_int)
		!line_speed_10 && live |=> rxd == $past(rx_line.dibit))
		else $error("Dibit not passed at 100 Mb/s");
	irq_level_a: assert property (@(posedge clk) disable iff (rst_int)
		irq == |(status_reg & enable_reg) && irq_out_n == !irq)
		else $error("Interrupt level does not follow enabled status");
	led_speed_a: assert property (@(posedge clk) disable iff (rst_int)
		wakeup_ctrl_status_next[LED_A_SEL_LSB +: SEL_W] == LEDSEL_SPEED |=> indicator_out_a == $past(line_speed_10))
		else $error("Indicator does not show speed");
	wake_pin_a: assert property (@(posedge clk) disable iff (rst_int)
		wake_detect |=> !wake_event_out_n && status_reg[EV_WAKE])
		else $error("Wake event not shown");
	shared_irq_a: assert property (@(posedge clk) disable iff (rst_int)
		straps.irq_pin_sel |-> shared_pin_oe == irq_reg && !shared_pin_o)
		else $error("Shared pin not carrying interrupt");
	bus_answer_a: assert property (@(posedge clk) disable iff (rst_int)
		(avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
		else $error("Bus answer too late");
	cover_10m_frame: cover property (@(posedge clk) disable iff (rst_int)
		state_reg == RX_HUNT ##1 state_reg == RX_PASS);
	cover_rx_error: cover property (@(posedge clk) disable iff (rst_int) rx_er && crs_dv);
	cover_irq: cover property (@(posedge clk) disable iff (rst_int) !irq_out_n);
endmodule : rpb_top
`default_nettype wire

//--- rpb_mac_model.sv
// Behavioural MAC transmit side facing the reduced interface
`default_nettype none
`timescale 1ns/1ps
module rpb_mac_model (
	input wire logic clk, // Shared reference clock
	output logic [1:0] txd, // Transmit dibit
	output logic tx_en // Transmit enable
);
	logic [1:0] dibit_q[$];
	logic idle_q = 1'b0;

	// ----------------------------------------------------------------
	// Loading: bytes leave least significant dibit first
	// ----------------------------------------------------------------
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 4; i++)
			dibit_q.push_back(b[2*i +: 2]);
	endtask : send

	// ----------------------------------------------------------------
	// Line driver
	// ----------------------------------------------------------------
	// Idle data toggles every cycle, so the block cannot lean on a stale dibit
	always @(posedge clk)
	begin
		idle_q <= ~idle_q;
		if (dibit_q.size() != 0)
		begin
			tx_en <= 1'b1;
			txd <= dibit_q.pop_front();
		end
		else
		begin
			tx_en <= 1'b0;
			txd <= {2{idle_q}};
		end
	end
endmodule : rpb_mac_model
`default_nettype wire

//--- rmii_phy_pin_behaviour_tb.sv
// Self-checking testbench of the reduced-interface transceiver pin block
`default_nettype none
`timescale 1ns/1ps
module rmii_phy_pin_behaviour_tb
	import rpb_pkg::*;
;
	logic clk = 1'b0, sys_rst = 1'b1, system_reset_n = 1'b1, refclk_src = 1'b0;
	logic line_speed_10 = 1'b0, line_full_duplex = 1'b1, line_link_up = 1'b0, wake_detect = 1'b0;
	logic [2:0] opm = 3'h5;
	logic addr_s = 1'b1, sel_s = 1'b1;
	rpb_rx_line_t rx_line = '0;
	logic [ADDR_W-1:0] avs_address = '0;
	logic avs_read = 1'b0, avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [1:0] txd, rxd, tx_line_dibit, txd_q;
	logic tx_en, crs_dv, rx_er, tx_line_en, txen_q, mgmt_addr, indicator_out_a, indicator_out_b;
	logic irq_out_n, wake_event_out_n, shared_pin_o, shared_pin_oe, irq, avs_waitrequest;
	logic [2:0] default_opmode;
	logic [31:0] avs_readdata;
	int errors = 0, total_checks = 0;

	always #10 clk = ~clk;
	always @(posedge clk)
	begin
		refclk_src <= ~refclk_src;
		txd_q <= txd;
		txen_q <= tx_en;
	end

	rpb_mac_model mac (.clk(clk), .txd(txd), .tx_en(tx_en));

	rpb_top dut (.clk(clk), .sys_rst(sys_rst), .system_reset_n(system_reset_n), .refclk_src(refclk_src),
		.txd(txd), .tx_en(tx_en), .rxd(rxd), .crs_dv(crs_dv), .rx_er(rx_er), .tx_line_dibit(tx_line_dibit),
		.tx_line_en(tx_line_en), .rx_line(rx_line), .line_speed_10(line_speed_10),
		.line_full_duplex(line_full_duplex), .line_link_up(line_link_up), .wake_detect(wake_detect),
		.opmode_strap_bit0(opm[0]), .opmode_strap_bit1(opm[1]), .opmode_strap_bit2(opm[2]),
		.mgmt_addr_strap(addr_s), .irq_pin_select_strap(sel_s), .default_opmode(default_opmode),
		.mgmt_addr(mgmt_addr), .indicator_out_a(indicator_out_a), .indicator_out_b(indicator_out_b),
		.irq_out_n(irq_out_n), .wake_event_out_n(wake_event_out_n), .shared_pin_o(shared_pin_o),
		.shared_pin_oe(shared_pin_oe), .irq(irq), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		if (errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict

	// Request held until the edge at which waitrequest is seen low
	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check("register read", q, exp);
	endtask : rd

	// Each step drives one line nibble and judges the output of the previous step
	task automatic rx_seq(input logic [47:0] v, input logic [47:0] e, input int n);
		for (int i = n - 1; i >= 0; i--)
		begin
			@(posedge clk);
			rx_line <= v[4*i +: 4];
			@(negedge clk);
			check("crs_dv rx_er rxd", {crs_dv, rx_er, rxd}, e[4*i +: 4]);
		end
	endtask : rx_seq

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_power_straps();
		check("opmode", default_opmode, 3'h5);
		check("mgmt addr", mgmt_addr, 1'b1);
		check("pin oe idle irq", shared_pin_oe, 1'b0);
		rd(REG_STRAP, 32'h17);
	endtask : t_power_straps

	task automatic t_transmit();
		int n;
		n = 0;
		@(negedge clk);
		mac.send(8'hD5);
		mac.send(8'h3C);
		repeat (12)
		begin
			@(negedge clk);
			check("tx line", {tx_line_en, tx_line_dibit & {2{tx_line_en}}}, {txen_q, txd_q & {2{txen_q}}});
			n += int'(tx_line_en === 1'b1);
		end
		check("tx dibits", n, 8);
	endtask : t_transmit

	task automatic t_receive();
		rx_seq(48'hA9FB00, 48'h0A9FB0, 6);
		rd(REG_STATUS, 32'h3);
		wr(REG_CLEAR, 32'hF);
		@(posedge clk);
		line_speed_10 <= 1'b1;
		rx_seq(48'h9999BAAA9A00, 48'h0888888889A0, 12);
		check("carrier", crs_dv, 1'b0);
	endtask : t_receive

	task automatic t_no_echo();
		int n;
		logic prev;
		n = 0;
		prev = 1'b0;
		@(posedge clk);
		line_full_duplex <= 1'b0;
		@(negedge clk);
		mac.send(8'h00);
		mac.send(8'h00);
		repeat (12)
		begin
			@(posedge clk);
			rx_line <= 4'hD;
			@(negedge clk);
			if (tx_line_en === 1'b1 && prev === 1'b1)
			begin
				check("echo", {crs_dv, rx_er, rxd}, 4'h0);
				n++;
			end
			prev = tx_line_en;
		end
		check("echo cycles", n, 7);
		@(posedge clk);
		rx_line <= 4'h0;
		line_full_duplex <= 1'b1;
		line_speed_10 <= 1'b0;
	endtask : t_no_echo

	task automatic t_events();
		rd(REG_WAKEUP_CTRL, {28'h0, WAKEUP_CTRL_RST});
		rd(5'h14, 32'h0);
		wr(REG_CLEAR, 32'hF);
		wr(REG_STATUS, 32'hF);
		rd(REG_STATUS, 32'h0);
		wr(REG_ENABLE, 32'h0);
		@(posedge clk);
		wake_detect <= 1'b1;
		@(posedge clk);
		wake_detect <= 1'b0;
		line_speed_10 <= 1'b1;
		repeat (2) @(negedge clk);
		check("masked irq", {irq, irq_out_n, wake_event_out_n}, 3'b010);
		for (int s = 0; s < 4; s++)
		begin
			wr(REG_WAKEUP_CTRL, s * 5);
			repeat (2) @(negedge clk);
			check("indicators", {indicator_out_a, indicator_out_b}, {2{s == 1 || s == 2}});
		end
		wr(REG_ENABLE, 32'h1 << EV_WAKE);
		repeat (2) @(negedge clk);
		check("irq pins", {irq, irq_out_n, shared_pin_oe, shared_pin_o}, 4'b1010);
		@(posedge clk);
		line_link_up <= 1'b1;
		rd(REG_STATUS, 32'hC);
		wr(REG_CLEAR, 32'hC);
		repeat (2) @(negedge clk);
		check("cleared", {irq, irq_out_n, wake_event_out_n, shared_pin_oe}, 4'b0110);
		rd(REG_STATUS, 32'h0);
	endtask : t_events

	task automatic t_pin_reset();
		@(posedge clk);
		opm <= 3'h2;
		addr_s <= 1'b0;
		sel_s <= 1'b0;
		repeat (6) @(posedge clk);
		system_reset_n <= 1'b0;
		repeat (12) @(posedge clk);
		system_reset_n <= 1'b1;
		repeat (12) @(negedge clk);
		check("opmode", default_opmode, 3'h2);
		check("mgmt addr", mgmt_addr, 1'b0);
		check("clock pin", {shared_pin_oe, shared_pin_o}, {1'b1, refclk_src});
		@(negedge clk);
		check("clock pin", {shared_pin_oe, shared_pin_o}, {1'b1, refclk_src});
		rd(REG_STRAP, 32'h08);
		rd(REG_WAKEUP_CTRL, {28'h0, WAKEUP_CTRL_RST});
	endtask : t_pin_reset

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (10) @(negedge clk);
		t_power_straps();
		t_transmit();
		t_receive();
		t_no_echo();
		t_events();
		t_pin_reset();
		print_verdict();
	end

	initial
	begin
		repeat (5000) @(posedge clk);
		errors++;
		print_verdict();
	end
endmodule : rmii_phy_pin_behaviour_tb
`default_nettype wire
